// >>> include/ppr_pkg.sv
/*
 * Shared constants for the pack protection register bank: register addresses,
 * field positions, writable masks, reset values, serial timing and FSM states.
 * Assumes a 10 MHz system clock and a two-wire serial bus running at 100 kHz or less.
 */
package ppr_pkg;

	localparam logic [7:0] ADDR_DEV_STATUS = 8'h00;
	localparam logic [7:0] ADDR_FAULT      = 8'h01;
	localparam logic [7:0] ADDR_BALANCE    = 8'h02;
	localparam logic [7:0] ADDR_ANALOG     = 8'h03;
	localparam logic [7:0] ADDR_SWITCH     = 8'h04;
	localparam logic [7:0] ADDR_DSET       = 8'h05;
	localparam logic [7:0] ADDR_CSET       = 8'h06;
	localparam logic [7:0] ADDR_FEATURE    = 8'h07;
	localparam logic [7:0] ADDR_UNLOCK     = 8'h08;

	localparam int SINGLE_FE_BIT   = 5;
	localparam int WAKE_STAT_BIT   = 4;
	localparam logic SINGLE_FE_VAL = 1'b1;

	localparam int SLEEP_BIT      = 7;
	localparam int LDMON_BIT      = 6;
	localparam int CHG_SW_BIT     = 1;
	localparam int DIS_SW_BIT     = 0;
	localparam int DOC_AUTO_OFF   = 7;
	localparam int SC_AUTO_OFF    = 4;
	localparam int COC_AUTO_OFF   = 7;
	localparam int WAKE_DIS_BIT   = 1;
	localparam int WAKE_POL_BIT   = 0;
	localparam int FEAT_UNL_BIT   = 7;
	localparam int CHG_UNL_BIT    = 6;
	localparam int DIS_UNL_BIT    = 5;

	localparam logic [7:0] MASK_BALANCE = 8'hFE;
	localparam logic [7:0] MASK_ANALOG  = 8'hCF;
	localparam logic [7:0] MASK_SWITCH  = 8'hC3;
	localparam logic [7:0] MASK_FULL    = 8'hFF;
	localparam logic [7:0] MASK_UNLOCK  = 8'hF8;
	localparam logic [7:0] REG_RESET    = 8'h00;
	localparam logic [5:0] FAULT_RESET  = 6'h00;

	localparam int CLK_NS   = 100;
	localparam int HOLD_NS  = 300;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;

	localparam int SY_SCL  = 0;
	localparam int SY_SDA  = 1;
	localparam int SY_WAKE = 2;
	localparam int SY_COND = 3;
	localparam int SY_W    = 9;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'h0,
		ST_START    = 4'h1,
		ST_ADDR     = 4'h2,
		ST_ACK_ADDR = 4'h3,
		ST_RXREG    = 4'h4,
		ST_ACK_REG  = 4'h5,
		ST_RXDAT    = 4'h6,
		ST_ACK_DAT  = 4'h7,
		ST_TX       = 4'h8,
		ST_MACK     = 4'h9
	} ppr_state_e;

endpackage : ppr_pkg

// >>> include/ppr_sync_if.sv
/*
 * Carrier between the register bank and its input synchroniser: raw pins in,
 * settled levels and one-cycle edge pulses out.
 * Assumes the synchroniser and its user share one clock.
 */
`timescale 1ns/1ns
interface ppr_sync_if #(parameter int W = 9);
	logic [W-1:0] raw;
	logic [W-1:0] level;
	logic [W-1:0] rise;
	logic [W-1:0] fall;
	modport syn (input raw, output level, output rise, output fall);
	modport usr (output raw, input level, input rise, input fall);
endinterface : ppr_sync_if

// >>> rtl/ppr_sync.sv
/*
 * Two-flop synchroniser with edge detection for a group of asynchronous inputs.
 * Assumes every raw bit may change at any time relative to clock.
 */
`timescale 1ns/1ns
module ppr_sync #(
	parameter int W = 9
) (
	input wire logic clock,
	input wire logic nrst,
	ppr_sync_if.syn  io
);
	logic [W-1:0] meta_r;
	logic [W-1:0] stab_r;
	logic [W-1:0] last_r;

	if (W < 1) begin : g_bad_width
		$error("ppr_sync: width must be at least one");
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_r <= '0;
			stab_r <= '0;
			last_r <= '0;
		end else begin
			meta_r <= io.raw;
			stab_r <= meta_r;
			last_r <= stab_r;
		end
	end

	assign io.level = stab_r;
	assign io.rise  = stab_r & ~last_r;
	assign io.fall  = ~stab_r & last_r;
endmodule : ppr_sync

// >>> rtl/ppr_regbank.sv
/*
 * Register bank of a pack protection front end with its two-wire serial slave.
 * Assumes scl, sda and the analog condition inputs are asynchronous and the
 * board resolves the open-drain data line from sda_oe.
 */
`timescale 1ns/1ns
// Operation
// - Status register 00H: fixed flag, wake status.
// - Fault register 01H holds six fault flags.
// - Faults clear on read once condition gone.
// - Writing one acts; reading one means present.
// - Switch register 04H: sleep, monitor, two switches.
// - Sleep cleared by reset, write, wake edge.
// - Automatic trips clear both switch bits.
// - Host writes drive switches; reads show drive.
// - Discharge setup register 05H field layout.
// - Discharge setup writes need its unlock bit.
// - Charge setup register 06H field layout.
// - Charge setup writes need its unlock bit.
// - Feature register 07H field layout.
// - Feature writes need unlock bit seven.
// - Unlock register 08H: enables and user flags.
// - Hold data output 300ns after clock fall.
// - Wake status follows pin under polarity.
// - Balance bits 7 to 1 switch cells.
module ppr_regbank #(
	parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary bus address.
) (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       scl,
	input  wire logic       sda_in,
	output wire logic       sda_out,
	output wire logic       sda_oe,
	input  wire logic       wake_pin,
	input  wire logic       cond_ext_ot,
	input  wire logic       cond_int_ot,
	input  wire logic       cond_load_fail,
	input  wire logic       cond_short,
	input  wire logic       cond_disch_oc,
	input  wire logic       cond_chg_oc,
	output wire logic [7:0] balance_switch_control,
	output wire logic [7:0] analog_mux_select,
	output wire logic       force_sleep,
	output wire logic       load_monitor_connect_enable,
	output wire logic       charge_switch_on,
	output wire logic       discharge_switch_on,
	output wire logic [7:0] discharge_protect_setup,
	output wire logic [7:0] charge_protect_setup,
	output wire logic [7:0] feature_setup,
	output wire logic [7:0] write_unlock
);
	localparam logic [2:0] HOLD_LOAD = 3'(ppr_pkg::HOLD_CYC);
	localparam logic [2:0] LAST_BIT  = 3'h7;
	if (ppr_pkg::HOLD_CYC < 1 || ppr_pkg::HOLD_CYC > 7) begin : g_bad_hold
		$error("ppr_regbank: hold count does not fit its counter");
	end
	ppr_sync_if #(.W(ppr_pkg::SY_W)) sy ();
	ppr_pkg::ppr_state_e st_r;
	logic [2:0]          cnt_r;
	logic [7:0]          shf_r;
	logic [7:0]          tx_r;
	logic [7:0]          ptr_r;
	logic                rw_r;
	logic                nack_r;
	logic [2:0]          hold_r;
	logic                sda_oe_r;
	logic [7:0]          bal_r;
	logic [7:0]          amux_r;
	logic [7:0]          swc_r;
	logic [7:0]          dset_r;
	logic [7:0]          cset_r;
	logic [7:0]          feat_r;
	logic [7:0]          unl_r;
	logic [5:0]          flt_r;
	logic                trip_r;
	logic                scl_hi;
	logic                scl_rise;
	logic                scl_fall;
	logic                sda_lv;
	logic                start_det;
	logic                stop_det;
	logic                wr_stb;
	logic                rd_load;
	logic [7:0]          rd_addr;
	logic                fault_rd;
	logic [5:0]          cond;
	logic                wake_lv;
	logic                wake_stat;
	logic                wake_evt;
	logic                trip;
	logic                auto_off;
	logic                drive_low;
	assign sy.raw = {cond_ext_ot, cond_int_ot, cond_load_fail, cond_short,
		cond_disch_oc, cond_chg_oc, wake_pin, sda_in, scl};
	ppr_sync #(
		.W (ppr_pkg::SY_W)
	) u_sync (
		.clock (clock),
		.nrst  (nrst),
		.io    (sy)
	);
	// Register address after a completed byte; unsupported locations fold back to zero.
	function automatic logic [7:0] next_ptr(input logic [7:0] p);
		if (p >= ppr_pkg::ADDR_UNLOCK) begin
			return ppr_pkg::ADDR_DEV_STATUS;
		end
		return p + 8'h01;
	endfunction : next_ptr
	// Read image of one register; reserved bits and unmapped addresses read zero.
	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			ppr_pkg::ADDR_DEV_STATUS: begin
				v[ppr_pkg::SINGLE_FE_BIT] = ppr_pkg::SINGLE_FE_VAL;
				v[ppr_pkg::WAKE_STAT_BIT] = wake_stat;
			end
			ppr_pkg::ADDR_FAULT:   v = {2'h0, flt_r};
			ppr_pkg::ADDR_BALANCE: v = bal_r;
			ppr_pkg::ADDR_ANALOG:  v = amux_r;
			ppr_pkg::ADDR_SWITCH:  v = swc_r;
			ppr_pkg::ADDR_DSET:    v = dset_r;
			ppr_pkg::ADDR_CSET:    v = cset_r;
			ppr_pkg::ADDR_FEATURE: v = feat_r;
			ppr_pkg::ADDR_UNLOCK:  v = unl_r;
			default:               v = 8'h00;
		endcase
		return v;
	endfunction : rd_mux
	assign scl_hi    = sy.level[ppr_pkg::SY_SCL];
	assign scl_rise  = sy.rise[ppr_pkg::SY_SCL];
	assign scl_fall  = sy.fall[ppr_pkg::SY_SCL];
	assign sda_lv    = sy.level[ppr_pkg::SY_SDA];
	assign start_det = sy.fall[ppr_pkg::SY_SDA] & scl_hi;
	assign stop_det  = sy.rise[ppr_pkg::SY_SDA] & scl_hi;
	assign wr_stb   = scl_fall && st_r == ppr_pkg::ST_RXDAT && cnt_r == LAST_BIT;
	assign rd_load  = scl_fall && ((st_r == ppr_pkg::ST_ACK_ADDR && rw_r)
		|| (st_r == ppr_pkg::ST_MACK && !nack_r));
	assign rd_addr  = (st_r == ppr_pkg::ST_MACK) ? next_ptr(ptr_r) : ptr_r;
	assign fault_rd = rd_load && rd_addr == ppr_pkg::ADDR_FAULT;
	assign cond      = sy.level[ppr_pkg::SY_COND +: 6];
	assign wake_lv   = sy.level[ppr_pkg::SY_WAKE];
	assign wake_stat = feat_r[ppr_pkg::WAKE_POL_BIT] ? wake_lv : ~wake_lv;
	assign wake_evt  = ~feat_r[ppr_pkg::WAKE_DIS_BIT]
		& (feat_r[ppr_pkg::WAKE_POL_BIT] ? sy.rise[ppr_pkg::SY_WAKE]
		: sy.fall[ppr_pkg::SY_WAKE]);
	// A trip only counts while its automatic response is enabled.
	assign trip = (cond[1] & ~dset_r[ppr_pkg::DOC_AUTO_OFF])
		| (cond[2] & ~dset_r[ppr_pkg::SC_AUTO_OFF])
		| (cond[0] & ~cset_r[ppr_pkg::COC_AUTO_OFF]);
	assign auto_off = trip & ~trip_r;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			trip_r <= 1'b0;
		end else begin
			trip_r <= trip;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			shf_r  <= 8'h00;
			nack_r <= 1'b0;
		end else if (scl_rise) begin
			shf_r <= {shf_r[6:0], sda_lv};
			if (st_r == ppr_pkg::ST_MACK) begin
				nack_r <= sda_lv;
			end
		end
	end
	// Protocol engine: bits are taken on scl rise, state moves on scl fall.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_r  <= ppr_pkg::ST_IDLE;
			cnt_r <= 3'h0;
			rw_r  <= 1'b0;
			ptr_r <= 8'h00;
			tx_r  <= 8'h00;
		end else if (stop_det) begin
			st_r <= ppr_pkg::ST_IDLE;
		end else if (start_det) begin
			st_r  <= ppr_pkg::ST_START;
			cnt_r <= 3'h0;
		end else if (scl_fall) begin
			case (st_r)
				ppr_pkg::ST_START: st_r <= ppr_pkg::ST_ADDR;
				ppr_pkg::ST_ADDR: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == LAST_BIT) begin
						if (shf_r[7:1] == DEV_ADDR) begin
							st_r <= ppr_pkg::ST_ACK_ADDR;
							rw_r <= shf_r[0];
						end else begin
							st_r <= ppr_pkg::ST_IDLE;
						end
					end
				end
				ppr_pkg::ST_ACK_ADDR: begin
					if (rw_r) begin
						tx_r <= rd_mux(rd_addr);
						st_r <= ppr_pkg::ST_TX;
					end else begin
						st_r <= ppr_pkg::ST_RXREG;
					end
				end
				ppr_pkg::ST_RXREG: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == LAST_BIT) begin
						ptr_r <= shf_r;
						st_r  <= ppr_pkg::ST_ACK_REG;
					end
				end
				ppr_pkg::ST_ACK_REG: st_r <= ppr_pkg::ST_RXDAT;
				ppr_pkg::ST_RXDAT: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == LAST_BIT) begin
						st_r <= ppr_pkg::ST_ACK_DAT;
					end
				end
				ppr_pkg::ST_ACK_DAT: begin
					ptr_r <= next_ptr(ptr_r);
					st_r  <= ppr_pkg::ST_RXDAT;
				end
				ppr_pkg::ST_TX: begin
					cnt_r <= cnt_r + 3'h1;
					tx_r  <= {tx_r[6:0], 1'b0};
					if (cnt_r == LAST_BIT) begin
						st_r <= ppr_pkg::ST_MACK;
					end
				end
				ppr_pkg::ST_MACK: begin
					if (nack_r) begin
						st_r <= ppr_pkg::ST_IDLE;
					end else begin
						ptr_r <= next_ptr(ptr_r);
						tx_r  <= rd_mux(rd_addr);
						st_r  <= ppr_pkg::ST_TX;
					end
				end
				default: st_r <= ppr_pkg::ST_IDLE;
			endcase
		end
	end
	always_comb begin
		case (st_r)
			ppr_pkg::ST_ACK_ADDR: drive_low = 1'b1;
			ppr_pkg::ST_ACK_REG:  drive_low = 1'b1;
			ppr_pkg::ST_ACK_DAT:  drive_low = 1'b1;
			ppr_pkg::ST_TX:       drive_low = ~tx_r[7];
			default:              drive_low = 1'b0;
		endcase
	end
	// The data line only changes a full hold time after scl is seen low, so the
	// host never samples a changing bit across the slow scl fall.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hold_r   <= 3'h0;
			sda_oe_r <= 1'b0;
		end else begin
			if (scl_fall) begin
				hold_r <= HOLD_LOAD;
			end else if (hold_r != 3'h0) begin
				hold_r <= hold_r - 3'h1;
			end
			if (hold_r == 3'h1) begin
				sda_oe_r <= drive_low;
			end else if (st_r == ppr_pkg::ST_IDLE && scl_hi) begin
				sda_oe_r <= 1'b0;
			end
		end
	end
	// Set wins over clear: a condition still present keeps its flag through a read.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			flt_r <= ppr_pkg::FAULT_RESET;
		end else begin
			flt_r <= {cond[5:4], cond[3] & swc_r[ppr_pkg::LDMON_BIT], cond[2:0]}
				| (flt_r & ~{6{fault_rd}});
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			bal_r <= ppr_pkg::REG_RESET;
		end else if (wr_stb && ptr_r == ppr_pkg::ADDR_BALANCE) begin
			bal_r <= shf_r & ppr_pkg::MASK_BALANCE;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			amux_r <= ppr_pkg::REG_RESET;
		end else if (wr_stb && ptr_r == ppr_pkg::ADDR_ANALOG) begin
			amux_r <= shf_r & ppr_pkg::MASK_ANALOG;
		end
	end
	// Hardware clears are applied after the host write so they win in a tie.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			swc_r <= ppr_pkg::REG_RESET;
		end else begin
			if (wr_stb && ptr_r == ppr_pkg::ADDR_SWITCH) begin
				swc_r <= shf_r & ppr_pkg::MASK_SWITCH;
			end
			if (wake_evt) begin
				swc_r[ppr_pkg::SLEEP_BIT] <= 1'b0;
			end
			if (auto_off) begin
				swc_r[ppr_pkg::CHG_SW_BIT] <= 1'b0;
				swc_r[ppr_pkg::DIS_SW_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dset_r <= ppr_pkg::REG_RESET;
		end else if (wr_stb && ptr_r == ppr_pkg::ADDR_DSET
			&& unl_r[ppr_pkg::DIS_UNL_BIT]) begin
			dset_r <= shf_r & ppr_pkg::MASK_FULL;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cset_r <= ppr_pkg::REG_RESET;
		end else if (wr_stb && ptr_r == ppr_pkg::ADDR_CSET
			&& unl_r[ppr_pkg::CHG_UNL_BIT]) begin
			cset_r <= shf_r & ppr_pkg::MASK_FULL;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			feat_r <= ppr_pkg::REG_RESET;
		end else if (wr_stb && ptr_r == ppr_pkg::ADDR_FEATURE
			&& unl_r[ppr_pkg::FEAT_UNL_BIT]) begin
			feat_r <= shf_r & ppr_pkg::MASK_FULL;
		end
	end
	// Writes to 09H and above match no register and change nothing.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			unl_r <= ppr_pkg::REG_RESET;
		end else if (wr_stb && ptr_r == ppr_pkg::ADDR_UNLOCK) begin
			unl_r <= shf_r & ppr_pkg::MASK_UNLOCK;
		end
	end

	assign sda_out                     = 1'b0;
	assign sda_oe                      = sda_oe_r;
	assign balance_switch_control      = bal_r;
	assign analog_mux_select           = amux_r;
	assign force_sleep                 = swc_r[ppr_pkg::SLEEP_BIT];
	assign load_monitor_connect_enable = swc_r[ppr_pkg::LDMON_BIT];
	assign charge_switch_on            = swc_r[ppr_pkg::CHG_SW_BIT];
	assign discharge_switch_on         = swc_r[ppr_pkg::DIS_SW_BIT];
	assign discharge_protect_setup     = dset_r;
	assign charge_protect_setup        = cset_r;
	assign feature_setup               = feat_r;
	assign write_unlock                = unl_r;
endmodule : ppr_regbank

// >>> testbench/ppr_regbank_chk_sva.sv
/* Concurrent checks on the ports of the pack protection register bank.
 * Assumes it is bound to every ppr_regbank and that nrst resets the whole bank. */
`timescale 1ns/1ns
module ppr_regbank_chk (
	input wire logic       clock,
	input wire logic       nrst,
	input wire logic       scl,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       wake_pin,
	input wire logic       cond_short,
	input wire logic       cond_disch_oc,
	input wire logic       cond_chg_oc,
	input wire logic [7:0] balance_switch_control,
	input wire logic [7:0] analog_mux_select,
	input wire logic       force_sleep,
	input wire logic       charge_switch_on,
	input wire logic       discharge_switch_on,
	input wire logic [7:0] discharge_protect_setup,
	input wire logic [7:0] charge_protect_setup,
	input wire logic [7:0] feature_setup,
	input wire logic [7:0] write_unlock
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	// Any enabled trip; the bank reacts to the rise of the combined condition only.
	wire logic trip = (cond_disch_oc & !discharge_protect_setup[7])
		| (cond_short & !discharge_protect_setup[4]) | (cond_chg_oc & !charge_protect_setup[7]);
	property p_hold; $fell(scl) |=> $stable(sda_oe) [*3]; endproperty
	a_hold: assert property (p_hold) else $error("sda changed too soon after scl fall");
	property p_od; sda_out == 1'b0; endproperty
	a_od: assert property (p_od) else $error("sda driven high");
	property p_rsv; balance_switch_control[0] == 1'b0 && analog_mux_select[5:4] == 2'h0
		&& write_unlock[2:0] == 3'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	property p_dlock; $changed(discharge_protect_setup) |-> $past(write_unlock[5]); endproperty
	a_dlock: assert property (p_dlock) else $error("locked discharge setup changed");
	property p_clock; $changed(charge_protect_setup) |-> $past(write_unlock[6]); endproperty
	a_clock: assert property (p_clock) else $error("locked charge setup changed");
	property p_flock; $changed(feature_setup) |-> $past(write_unlock[7]); endproperty
	a_flock: assert property (p_flock) else $error("locked feature setup changed");
	property p_trip; $rose(trip) |-> ##[1:6] (!charge_switch_on && !discharge_switch_on); endproperty
	a_trip: assert property (p_trip) else $error("switches not cleared on trip");
	property p_wake; $rose(wake_pin) && feature_setup[0] && !feature_setup[1]
		|-> ##[1:6] !force_sleep; endproperty
	a_wake: assert property (p_wake) else $error("sleep not cleared by wake");
endmodule : ppr_regbank_chk

bind ppr_regbank ppr_regbank_chk ppr_regbank_chk_inst (.clock(clock), .nrst(nrst), .scl(scl),
	.sda_out(sda_out), .sda_oe(sda_oe), .wake_pin(wake_pin), .cond_short(cond_short),
	.cond_disch_oc(cond_disch_oc), .cond_chg_oc(cond_chg_oc),
	.balance_switch_control(balance_switch_control), .analog_mux_select(analog_mux_select),
	.force_sleep(force_sleep), .charge_switch_on(charge_switch_on),
	.discharge_switch_on(discharge_switch_on), .discharge_protect_setup(discharge_protect_setup),
	.charge_protect_setup(charge_protect_setup), .feature_setup(feature_setup),
	.write_unlock(write_unlock));

// >>> testbench/ppr_host_model.sv
/* Host model on the two-wire register bus: drives scl and pulls sda low.
 * Assumes a pull-up on sda and the system clock for pacing. */
`timescale 1ns/1ns
module ppr_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	input  wire logic clock,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	// Low phase is stretched to 1.2 us since the slave answers about 600 ns after a fall.
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic wbit(input logic b);
		tick(1);
		sda_low <= !b;
		tick(11);
		scl <= 1'b1;
		tick(4);
		scl <= 1'b0;
	endtask : wbit
	task automatic rbit(output logic b);
		tick(1);
		sda_low <= 1'b0;
		tick(11);
		scl <= 1'b1;
		tick(2);
		b = sda;
		tick(2);
		scl <= 1'b0;
	endtask : rbit
	// The wait before scl rises lets the slave release its acknowledge first.
	task automatic start();
		tick(2);
		sda_low <= 1'b0;
		tick(8);
		scl <= 1'b1;
		tick(4);
		sda_low <= 1'b1;
		tick(4);
		scl <= 1'b0;
	endtask : start
	task automatic stop();
		tick(2);
		sda_low <= 1'b1;
		tick(10);
		scl <= 1'b1;
		tick(4);
		sda_low <= 1'b0;
		tick(8);
	endtask : stop
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) wbit(d[i]);
		rbit(a);
		ack = !a;
	endtask : wbyte
	task automatic write_reg(input logic [7:0] ra, input logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		wbyte({DEV_ADDR, 1'b0}, a0);
		wbyte(ra, a1);
		wbyte(d, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask : write_reg
	task automatic read_reg(input logic [7:0] ra, output logic [7:0] d);
		logic a;
		start();
		wbyte({DEV_ADDR, 1'b0}, a);
		wbyte(ra, a);
		start();
		wbyte({DEV_ADDR, 1'b1}, a);
		for (int i = 7; i >= 0; i--) rbit(d[i]);
		wbit(1'b1);
		stop();
	endtask : read_reg
	// Two-byte read: the host acknowledges the first byte so the pointer advances.
	task automatic read_two(input logic [7:0] ra, output logic [7:0] d0, output logic [7:0] d1);
		logic a;
		start();
		wbyte({DEV_ADDR, 1'b0}, a);
		wbyte(ra, a);
		start();
		wbyte({DEV_ADDR, 1'b1}, a);
		for (int i = 7; i >= 0; i--) rbit(d0[i]);
		wbit(1'b0);
		for (int i = 7; i >= 0; i--) rbit(d1[i]);
		wbit(1'b1);
		stop();
	endtask : read_two
endmodule : ppr_host_model

// >>> testbench/pack_protect_register_map_test.sv
/* Self-checking bench for the pack protection register bank.
 * Assumes the host model and the bound checker are compiled before it. */
`timescale 1ns/1ns
module pack_protect_register_map_test;
	logic       clock;
	logic       nrst;
	logic       wake_pin;
	logic [5:0] cond;
	logic       scl, sda_low, sda_oe, sda_out, force_sleep, ldmon, chg_on, dis_on;
	logic [7:0] bal, ana, dset, cset, feat, unl;
	int         n_fail = 0;
	int         checks = 0;
	int         cyc = 0;
	logic [7:0] val [3] = '{8'hA5, 8'h5A, 8'h3C};
	wire logic  sda = !(sda_low | sda_oe);
	ppr_regbank ppr_regbank_inst (.clock(clock), .nrst(nrst), .scl(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .wake_pin(wake_pin), .cond_ext_ot(cond[5]),
		.cond_int_ot(cond[4]), .cond_load_fail(cond[3]), .cond_short(cond[2]),
		.cond_disch_oc(cond[1]), .cond_chg_oc(cond[0]), .balance_switch_control(bal),
		.analog_mux_select(ana), .force_sleep(force_sleep), .load_monitor_connect_enable(ldmon),
		.charge_switch_on(chg_on), .discharge_switch_on(dis_on), .discharge_protect_setup(dset),
		.charge_protect_setup(cset), .feature_setup(feat), .write_unlock(unl));
	ppr_host_model ppr_host_model_inst (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
	task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wr(input logic [7:0] ra, input logic [7:0] d);
		logic ok;
		ppr_host_model_inst.write_reg(ra, d, ok);
		check("write ack", {7'h00, ok}, 8'h01);
	endtask : wr
	task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
		logic [7:0] d;
		ppr_host_model_inst.read_reg(ra, d);
		check($sformatf("register %h", ra), d, exp);
	endtask : rd
	task automatic drive(input logic [5:0] v);
		@(posedge clock);
		cond <= v;
		repeat (10) @(posedge clock);
	endtask : drive
	task automatic t_reset_values();
		rd(8'h00, 8'h30);
		for (int a = 1; a < 9; a++) rd(a[7:0], 8'h00);
		$display("test reset_values done");
	endtask : t_reset_values
	task automatic t_plain_rw();
		logic [7:0] d0, d1;
		wr(8'h02, 8'hFE);
		wr(8'h03, 8'hCF);
		wr(8'h08, 8'h18);
		wr(8'h04, 8'h43);
		rd(8'h02, 8'hFE);
		rd(8'h03, 8'hCF);
		rd(8'h08, 8'h18);
		rd(8'h04, 8'h43);
		check("balance", bal, 8'hFE);
		check("analog", ana, 8'hCF);
		check("drive", {force_sleep, ldmon, 4'h0, chg_on, dis_on}, 8'h43);
		check("unlock", unl, 8'h18);
		ppr_host_model_inst.read_two(8'h08, d0, d1);
		check("burst first", d0, 8'h18);
		check("burst wrap", d1, 8'h30);
		$display("test plain_rw done");
	endtask : t_plain_rw
	task automatic t_unlock();
		for (int i = 0; i < 3; i++) wr(8'h05 + i[7:0], val[i]);
		for (int i = 0; i < 3; i++) rd(8'h05 + i[7:0], 8'h00);
		wr(8'h08, 8'hF8);
		for (int i = 0; i < 3; i++) wr(8'h05 + i[7:0], val[i]);
		for (int i = 0; i < 3; i++) rd(8'h05 + i[7:0], val[i]);
		check("dset", dset, 8'hA5);
		check("cset", cset, 8'h5A);
		check("feature", feat, 8'h3C);
		wr(8'h08, 8'h18);
		wr(8'h05, 8'h00);
		rd(8'h05, 8'hA5);
		$display("test unlock done");
	endtask : t_unlock
	task automatic t_faults();
		drive(6'h39);
		check("drive", {force_sleep, ldmon, 4'h0, chg_on, dis_on}, 8'h40);
		rd(8'h01, 8'h39);
		drive(6'h00);
		rd(8'h01, 8'h39);
		rd(8'h01, 8'h00);
		wr(8'h04, 8'h43);
		drive(6'h02);
		check("drive", {force_sleep, ldmon, 4'h0, chg_on, dis_on}, 8'h43);
		drive(6'h00);
		drive(6'h04);
		check("drive", {force_sleep, ldmon, 4'h0, chg_on, dis_on}, 8'h40);
		drive(6'h00);
		rd(8'h01, 8'h06);
		$display("test faults done");
	endtask : t_faults
	task automatic t_sleep_wake();
		wr(8'h08, 8'h80);
		wr(8'h07, 8'h01);
		rd(8'h00, 8'h20);
		wr(8'h04, 8'h80);
		check("sleep", {7'h00, force_sleep}, 8'h01);
		@(posedge clock);
		wake_pin <= 1'b1;
		repeat (10) @(posedge clock);
		check("sleep", {7'h00, force_sleep}, 8'h00);
		rd(8'h00, 8'h30);
		wr(8'h04, 8'h80);
		wr(8'h04, 8'h00);
		check("sleep", {7'h00, force_sleep}, 8'h00);
		wr(8'h07, 8'h00);
		wr(8'h04, 8'h80);
		check("sleep", {7'h00, force_sleep}, 8'h01);
		@(posedge clock);
		wake_pin <= 1'b0;
		repeat (10) @(posedge clock);
		check("sleep", {7'h00, force_sleep}, 8'h00);
		rd(8'h00, 8'h30);
		wr(8'h08, 8'h00);
		$display("test sleep_wake done");
	endtask : t_sleep_wake
	task automatic t_refuse();
		logic ack;
		ppr_host_model_inst.start();
		ppr_host_model_inst.wbyte(8'h56, ack);
		check("foreign ack", {7'h00, ack}, 8'h00);
		ppr_host_model_inst.stop();
		rd(8'h09, 8'h00);
		$display("test refuse done");
	endtask : t_refuse
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 80000) begin
			n_fail++;
			report_and_stop();
		end
	end
	initial begin
		nrst = 1'b0;
		wake_pin = 1'b0;
		cond = 6'h00;
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		repeat (6) @(posedge clock);
		t_reset_values();
		t_plain_rw();
		t_unlock();
		t_faults();
		t_sleep_wake();
		t_refuse();
		report_and_stop();
	end
endmodule : pack_protect_register_map_test
